// [rtl/gpc_pkg.sv]
package gpc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] GPC_OFS_PORT_C_LATCH = 4'h2;
  localparam logic [3:0] GPC_OFS_PORT_D_LATCH = 4'h3;
  localparam logic [3:0] GPC_OFS_PORT_C_DIR   = 4'h6;
  localparam logic [3:0] GPC_OFS_PORT_D_DIR   = 4'h7;
  localparam logic [3:0] GPC_OFS_PORT_E_LATCH = 4'h8;
  localparam logic [3:0] GPC_OFS_PORT_E_DIR   = 4'hC;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         GPC_CLK_OUT_BIT  = 7;
  localparam int         GPC_CLK_OUT_PIN  = 2;
  localparam int         GPC_TA_CLK_PIN   = 6;
  localparam int         GPC_TB_CLK_PIN   = 4;
  localparam logic [7:0] GPC_DIR_RESET    = 8'h00;
  localparam logic [7:0] GPC_PORT_C_MASK  = 8'h3F;
  localparam logic [7:0] GPC_PORT_C_DIRECTION_RD_MASK = 8'hBF;
  localparam logic [4:0] GPC_CONV_D_FIRST = 5'h08;
  localparam logic [4:0] GPC_CONV_D_LAST  = 5'h0E;
  localparam logic [2:0] GPC_PS_EXT_CLK   = 3'h7;
  localparam logic [1:0] GPC_SYNC_RESET   = 2'h0;

  // Peripheral control inputs that decide pin ownership
  typedef struct packed {
    logic [4:0] conv_sel;
    logic [2:0] ta_prescale;
    logic [2:0] tb_prescale;
    logic [1:0] ta_ch0_els;
    logic [1:0] ta_ch1_els;
    logic       spi_en;
    logic       spi_master;
    logic       mode_fault_en;
    logic       sci_en;
  } gpc_ctrl_s;

  // Peripheral-side outputs onto port E
  typedef struct packed {
    logic       spi_clk_out;
    logic       spi_mosi_out;
    logic       spi_miso_out;
    logic [1:0] ta_ch_out;
    logic [1:0] ta_ch_oe;
    logic       sci_txd;
  } gpc_periph_s;

endpackage

// [rtl/gpc_ports.sv]
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
// Overview of operation
// - Port C latches writable, untouched by reset
// - Clock-out enable drives system clock on C2
// - Clock-out overrides port C pin 2 direction
// - Clock-out enable read/write, cleared by reset
// - Direction one drives pin, zero inputs
// - Reset clears whole port C direction
// - Port C read: latch if output, pin otherwise
// - Latch writes always land, input pins unaffected
// - Port D read: latch if output, pin otherwise
// - Reset clears port D direction
// - Converter-selected D input bits read zero
// - Timer-owned D pins ignore direction for drive
// - Timer clock select removes D6/D4 direction
// - E7..E5 belong to SPI when enabled
// - E4 slave select unless disabled or master-nofault
// - SPI slave: E4 direction ignored
// - Peripheral-owned E pins: direction only selects read
// - Edge/level select gives E3/E2 to timer
// - E1/E0 belong to SCI when enabled
// - Port E read: latch if output, pin otherwise
// - Reset clears port E direction
module gpc_ports
  import gpc_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic [3:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  input  wire gpc_ctrl_s   i_ctrl,
  input  wire gpc_periph_s i_periph,
  input  wire logic [5:0]  i_pc_pin,
  output logic      [5:0]  o_pc_out,
  output logic      [5:0]  o_pc_oe,
  input  wire logic [7:0]  i_pd_pin,
  output logic      [7:0]  o_pd_out,
  output logic      [7:0]  o_pd_oe,
  input  wire logic [7:0]  i_pe_pin,
  output logic      [7:0]  o_pe_out,
  output logic      [7:0]  o_pe_oe,
  output logic      [7:0]  o_pe_pin_sync
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [5:0] pc_latch_q;
  logic [7:0] pd_latch_q;
  logic [7:0] pe_latch_q;
  logic [5:0] pc_dir_q;
  logic       clk_out_en_q;
  logic [7:0] pd_dir_q;
  logic [7:0] pe_dir_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [21:0] s1_q;
  logic [21:0] s2_q;
  logic [21:0] s3_q;
  logic [21:0] pin_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire wr_pc  = i_wr && (i_addr == GPC_OFS_PORT_C_LATCH);
  wire wr_pd  = i_wr && (i_addr == GPC_OFS_PORT_D_LATCH);
  wire wr_pe  = i_wr && (i_addr == GPC_OFS_PORT_E_LATCH);
  wire wr_pcd = i_wr && (i_addr == GPC_OFS_PORT_C_DIR);
  wire wr_pdd = i_wr && (i_addr == GPC_OFS_PORT_D_DIR);
  wire wr_ped = i_wr && (i_addr == GPC_OFS_PORT_E_DIR);

  // Data latches: no reset, writes land whatever the direction
  always_ff @(posedge i_clk) begin
    if (wr_pc) pc_latch_q <= i_wdata[5:0];
    if (wr_pd) pd_latch_q <= i_wdata;
    if (wr_pe) pe_latch_q <= i_wdata;
  end

  // Direction registers, cleared by reset
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pc_dir_q     <= GPC_DIR_RESET[5:0];
      clk_out_en_q <= 1'b0;
      pd_dir_q     <= GPC_DIR_RESET;
      pe_dir_q     <= GPC_DIR_RESET;
    end else begin
      if (wr_pcd) begin
        pc_dir_q     <= i_wdata[5:0];
        clk_out_en_q <= i_wdata[GPC_CLK_OUT_BIT];
      end
      if (wr_pdd) pd_dir_q <= i_wdata;
      if (wr_ped) pe_dir_q <= i_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers: change accepted when stages two and three agree
  // ----------------------------------------------------------------
  wire [21:0] pins_raw = {i_pe_pin, i_pd_pin, i_pc_pin};

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      pin_q <= '0;
    end else begin
      s1_q  <= pins_raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      pin_q <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
    end
  end

  wire [5:0] pc_pin_s = pin_q[5:0];
  wire [7:0] pd_pin_s = pin_q[13:6];
  wire [7:0] pe_pin_s = pin_q[21:14];
  assign o_pe_pin_sync = pe_pin_s;

  // ----------------------------------------------------------------
  // Port C drive
  // ----------------------------------------------------------------
  logic [5:0] pc_oe_gpio;
  always_comb begin
    pc_oe_gpio = pc_dir_q;
    if (clk_out_en_q) pc_oe_gpio[GPC_CLK_OUT_PIN] = 1'b1;
  end

  logic [5:0] pc_out_mux;
  always_comb begin
    pc_out_mux = pc_latch_q;
    if (clk_out_en_q) pc_out_mux[GPC_CLK_OUT_PIN] = i_clk;
  end
  assign o_pc_out = pc_out_mux;
  assign o_pc_oe  = pc_oe_gpio;

  // ----------------------------------------------------------------
  // Port D ownership and drive
  // ----------------------------------------------------------------
  wire ta_ext = (i_ctrl.ta_prescale == GPC_PS_EXT_CLK);
  wire tb_ext = (i_ctrl.tb_prescale == GPC_PS_EXT_CLK);

  // Converter channel select to port D bit (channels 8..14 on D0..D6)
  function automatic logic [7:0] conv_bits(input logic [4:0] sel);
    logic [7:0] m;
    m = 8'h00;
    if (sel >= GPC_CONV_D_FIRST && sel <= GPC_CONV_D_LAST)
      m[3'(sel - GPC_CONV_D_FIRST)] = 1'b1;
    return m;
  endfunction

  wire [7:0] pd_conv = conv_bits(i_ctrl.conv_sel);
  logic [7:0] pd_owned;
  always_comb begin
    pd_owned = pd_conv;
    pd_owned[GPC_TA_CLK_PIN] = pd_owned[GPC_TA_CLK_PIN] | ta_ext;
    pd_owned[GPC_TB_CLK_PIN] = pd_owned[GPC_TB_CLK_PIN] | tb_ext;
  end
  assign o_pd_out = pd_latch_q;
  assign o_pd_oe  = pd_dir_q & ~pd_owned;

  // ----------------------------------------------------------------
  // Port E ownership and drive
  // ----------------------------------------------------------------
  wire spi_on    = i_ctrl.spi_en;
  wire ss_active = spi_on && !(i_ctrl.spi_master && !i_ctrl.mode_fault_en);
  wire ta0_on    = (i_ctrl.ta_ch0_els != 2'h0);
  wire ta1_on    = (i_ctrl.ta_ch1_els != 2'h0);
  wire sci_on    = i_ctrl.sci_en;

  logic [7:0] pe_owned;
  logic [7:0] pe_p_oe;
  logic [7:0] pe_p_out;
  always_comb begin
    pe_owned = {spi_on, spi_on, spi_on, ss_active, ta1_on, ta0_on, sci_on, sci_on};
    pe_p_oe  = 8'h00;
    pe_p_out = 8'h00;
    // SPI: master drives clock and MOSI, slave drives MISO
    pe_p_oe[7]  = spi_on && i_ctrl.spi_master;
    pe_p_oe[6]  = spi_on && i_ctrl.spi_master;
    pe_p_oe[5]  = spi_on && !i_ctrl.spi_master;
    pe_p_out[7] = i_periph.spi_clk_out;
    pe_p_out[6] = i_periph.spi_mosi_out;
    pe_p_out[5] = i_periph.spi_miso_out;
    // Slave select is always an input while owned
    pe_p_oe[4]  = 1'b0;
    pe_p_oe[3]  = ta1_on && i_periph.ta_ch_oe[1];
    pe_p_oe[2]  = ta0_on && i_periph.ta_ch_oe[0];
    pe_p_out[3:2] = i_periph.ta_ch_out;
    pe_p_oe[0]  = sci_on;
    pe_p_out[0] = i_periph.sci_txd;
  end
  assign o_pe_oe  = (pe_dir_q & ~pe_owned) | (pe_p_oe & pe_owned);
  assign o_pe_out = (pe_latch_q & ~pe_owned) | (pe_p_out & pe_owned);

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  function automatic logic [7:0] port_read(input logic [7:0] dir, input logic [7:0] lat,
                                           input logic [7:0] pin);
    return (dir & lat) | (~dir & pin);
  endfunction

  wire [7:0] pc_rd = port_read({2'h0, pc_dir_q}, {2'h0, pc_latch_q}, {2'h0, pc_pin_s});
  wire [7:0] pd_rd = port_read(pd_dir_q, pd_latch_q, pd_pin_s & ~pd_conv);
  wire [7:0] pe_rd = port_read(pe_dir_q, pe_latch_q, pe_pin_s);

  always_comb begin
    unique case (i_addr)
      GPC_OFS_PORT_C_LATCH: rdata_d = pc_rd & GPC_PORT_C_MASK;
      GPC_OFS_PORT_D_LATCH: rdata_d = pd_rd;
      GPC_OFS_PORT_C_DIR:   rdata_d = {clk_out_en_q, 1'b0, pc_dir_q} & GPC_PORT_C_DIRECTION_RD_MASK;
      GPC_OFS_PORT_D_DIR:   rdata_d = pd_dir_q;
      GPC_OFS_PORT_E_LATCH: rdata_d = pe_rd;
      GPC_OFS_PORT_E_DIR:   rdata_d = pe_dir_q;
      default:              rdata_d = 8'h00;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (i_reset) rdata_q <= 8'h00;
    else         rdata_q <= i_rd ? rdata_d : 8'h00;
  end
  assign o_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_reg_write(logic [3:0] a);
    i_wr && i_addr == a;
  endsequence

  sequence s_reg_read(logic [3:0] a);
    i_rd && i_addr == a;
  endsequence

  // Converter-owned port D inputs, a named net so that $past sees a signal
  wire [7:0] pd_conv_in = pd_conv & ~pd_dir_q;

  // Clock output takes pin C2
  a_clk_out_drive: assert property (@(posedge i_clk) disable iff (i_reset)
    clk_out_en_q |-> o_pc_oe[GPC_CLK_OUT_PIN])
    else $error("clock pin not driven");
  // Clock output drives C2 even with its direction bit low
  a_c2_dir_ignored: assert property (@(posedge i_clk) disable iff (i_reset)
    (clk_out_en_q && !pc_dir_q[GPC_CLK_OUT_PIN]) |-> o_pc_oe[GPC_CLK_OUT_PIN])
    else $error("C2 direction not ignored");
  // Without clock output the drive follows the direction bits
  a_pc_oe_dir: assert property (@(posedge i_clk) disable iff (i_reset)
    !clk_out_en_q |-> o_pc_oe == pc_dir_q)
    else $error("port C drive differs from direction");
  // Clock output enable lands on write
  a_clk_en_write: assert property (@(posedge i_clk) disable iff (i_reset)
    s_reg_write(GPC_OFS_PORT_C_DIR) |=> clk_out_en_q == $past(i_wdata[GPC_CLK_OUT_BIT]))
    else $error("clock enable write lost");
  // Clock output enable reads back in the top bit
  a_clk_en_read: assert property (@(posedge i_clk) disable iff (i_reset)
    s_reg_read(GPC_OFS_PORT_C_DIR) |=> o_rdata[GPC_CLK_OUT_BIT] == $past(clk_out_en_q))
    else $error("clock enable read wrong");

  // Reset clears every direction register and turns the clock output off
  a_reset_dirs: assert property (@(posedge i_clk)
    i_reset |=> (pc_dir_q == 6'h00 && pd_dir_q == 8'h00 && pe_dir_q == 8'h00 && !clk_out_en_q))
    else $error("direction not cleared");
  // Port C latch writes land, reset or not
  a_pc_latch: assert property (@(posedge i_clk)
    s_reg_write(GPC_OFS_PORT_C_LATCH) |=> pc_latch_q == $past(i_wdata[5:0]))
    else $error("port C latch write lost");
  // Port D latch writes land whatever the direction
  a_latch_update: assert property (@(posedge i_clk)
    s_reg_write(GPC_OFS_PORT_D_LATCH) |=> pd_latch_q == $past(i_wdata))
    else $error("latch write lost");
  // Port E latch writes land whatever the direction
  a_pe_latch: assert property (@(posedge i_clk)
    s_reg_write(GPC_OFS_PORT_E_LATCH) |=> pe_latch_q == $past(i_wdata))
    else $error("port E latch write lost");

  // Port C read: latch where direction set, synchronised pin elsewhere
  a_pc_read: assert property (@(posedge i_clk) disable iff (i_reset)
    s_reg_read(GPC_OFS_PORT_C_LATCH) |=>
    o_rdata == {2'h0, ($past(pc_dir_q) & $past(pc_latch_q)) | (~$past(pc_dir_q) & $past(pc_pin_s))})
    else $error("port C read wrong");
  // Port D read: latch where direction set, pin or zero elsewhere
  a_pd_read: assert property (@(posedge i_clk) disable iff (i_reset)
    s_reg_read(GPC_OFS_PORT_D_LATCH) |=>
    o_rdata == (($past(pd_dir_q) & $past(pd_latch_q)) | (~$past(pd_dir_q) & $past(pd_pin_s) & ~$past(pd_conv))))
    else $error("port D read wrong");
  // Converter-selected input bits read as zero
  a_conv_zero: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_rd && i_addr == GPC_OFS_PORT_D_LATCH && pd_conv_in != 8'h00) |=> (o_rdata & $past(pd_conv_in)) == 8'h00)
    else $error("converter bit not zero");
  // Timer-owned pin still reads its latch when the direction bit is set
  a_timer_read: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_rd && i_addr == GPC_OFS_PORT_D_LATCH && ta_ext && pd_dir_q[GPC_TA_CLK_PIN]) |=>
    o_rdata[GPC_TA_CLK_PIN] == $past(pd_latch_q[GPC_TA_CLK_PIN]))
    else $error("timer pin read wrong");
  // Free port D pins follow the direction bits
  a_pd_oe_free: assert property (@(posedge i_clk) disable iff (i_reset)
    (pd_conv == 8'h00 && !ta_ext && !tb_ext) |-> o_pd_oe == pd_dir_q)
    else $error("port D drive differs from direction");
  // Timer A external clock pin is never driven
  a_timer_clk_in: assert property (@(posedge i_clk) disable iff (i_reset)
    ta_ext |-> !o_pd_oe[GPC_TA_CLK_PIN])
    else $error("timer clock pin driven");
  // Timer B external clock pin is never driven
  a_timer_b_clk: assert property (@(posedge i_clk) disable iff (i_reset)
    tb_ext |-> !o_pd_oe[GPC_TB_CLK_PIN])
    else $error("timer B clock pin driven");

  // SPI off: E7..E5 follow their direction bits
  a_spi_gpio: assert property (@(posedge i_clk) disable iff (i_reset)
    !spi_on |-> o_pe_oe[7:5] == pe_dir_q[7:5])
    else $error("SPI pins not released");
  // SPI master drives its clock and data out
  a_spi_master_out: assert property (@(posedge i_clk) disable iff (i_reset)
    (spi_on && i_ctrl.spi_master) |-> (o_pe_oe[7:6] == 2'h3 && o_pe_out[7] == i_periph.spi_clk_out))
    else $error("SPI master pins wrong");
  // Master without mode fault leaves E4 general-purpose
  a_ss_owner: assert property (@(posedge i_clk) disable iff (i_reset)
    (spi_on && i_ctrl.spi_master && !i_ctrl.mode_fault_en) |-> o_pe_oe[4] == pe_dir_q[4])
    else $error("slave select not released");
  // Master with mode fault keeps E4 an input
  a_ss_modfault: assert property (@(posedge i_clk) disable iff (i_reset)
    (spi_on && i_ctrl.spi_master && i_ctrl.mode_fault_en) |-> !o_pe_oe[4])
    else $error("mode fault pin driven");
  // Slave select is an input while the SPI is a slave
  a_ss_input: assert property (@(posedge i_clk) disable iff (i_reset)
    (spi_on && !i_ctrl.spi_master) |-> !o_pe_oe[4])
    else $error("slave select driven");
  // SPI slave pins ignore their direction bits
  a_slave_dir: assert property (@(posedge i_clk) disable iff (i_reset)
    (spi_on && !i_ctrl.spi_master) |-> (o_pe_oe[7:6] == 2'h0 && o_pe_oe[5]))
    else $error("SPI slave pins wrong");
  // Free port E pins follow the direction bits
  a_pe_oe_free: assert property (@(posedge i_clk) disable iff (i_reset)
    !(spi_on || sci_on || ta0_on || ta1_on) |-> o_pe_oe == pe_dir_q)
    else $error("port E drive differs from direction");
  // Timer channel owns E2 drive when selected
  a_timer_e_drive: assert property (@(posedge i_clk) disable iff (i_reset)
    ta0_on |-> o_pe_oe[2] == i_periph.ta_ch_oe[0])
    else $error("timer channel drive wrong");
  // E2 is general-purpose when the channel is off
  a_timer_e_free: assert property (@(posedge i_clk) disable iff (i_reset)
    !ta0_on |-> o_pe_oe[2] == pe_dir_q[2])
    else $error("timer channel pin not released");
  // SCI drives transmit and listens on receive
  a_sci_txd: assert property (@(posedge i_clk) disable iff (i_reset)
    sci_on |-> (o_pe_oe[0] && !o_pe_oe[1]))
    else $error("SCI pins wrong");
  // SCI off: E1, E0 follow their direction bits
  a_sci_free: assert property (@(posedge i_clk) disable iff (i_reset)
    !sci_on |-> o_pe_oe[1:0] == pe_dir_q[1:0])
    else $error("SCI pins not released");
  // Port E read: latch where direction set, pin elsewhere
  a_pe_read: assert property (@(posedge i_clk) disable iff (i_reset)
    s_reg_read(GPC_OFS_PORT_E_LATCH) |=>
    o_rdata == (($past(pe_dir_q) & $past(pe_latch_q)) | (~$past(pe_dir_q) & $past(pe_pin_s))))
    else $error("port E read wrong");

  // Read data stand only in the cycle after a strobe
  a_rdata_idle: assert property (@(posedge i_clk) disable iff (i_reset)
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data without strobe");
  // Filtered level holds while stages two and three differ
  a_sync_agree: assert property (@(posedge i_clk) disable iff (i_reset)
    1'b1 |=> ((pin_q ^ $past(pin_q)) & ($past(s2_q) ^ $past(s3_q))) == 22'h0)
    else $error("pin filter moved on disagreement");
  // Filtered level takes the value that stages two and three agree on
  a_sync_take: assert property (@(posedge i_clk) disable iff (i_reset)
    1'b1 |=> (($past(s2_q) ~^ $past(s3_q)) & (pin_q ^ $past(s2_q))) == 22'h0)
    else $error("pin filter missed agreement");
endmodule

// [tb/gpc_pin_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Pad model: wire level from the port drive and the far side
// ----------------------------------------------------------------
module gpc_pin_model (
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_ext,
  output logic      [7:0] o_pin
);
  // Driven bits show the port value, released bits the far side level
  assign o_pin = (i_oe & i_out) | (~i_oe & i_ext);
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
module tb
  import gpc_pkg::*;
;
  logic        i_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic [3:0]  i_addr = 4'h0;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [7:0]  o_rdata;
  gpc_ctrl_s   i_ctrl = '0;
  gpc_periph_s i_periph = '0;
  logic [7:0]  ext_c = 8'h00;
  logic [7:0]  ext_d = 8'h00;
  logic [7:0]  ext_e = 8'h00;
  logic [7:0]  pc_pin, pd_pin, pe_pin, pd_out, pd_oe, pe_out, pe_oe, pe_sync, rd;
  logic [5:0]  pc_out, pc_oe;
  int          failures = 0;
  int          compares = 0;
  // ----------------------------------------------------------------
  // Clock, design and pads
  // ----------------------------------------------------------------
  initial forever #12.5 i_clk = ~i_clk;
  gpc_ports i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_ctrl(i_ctrl), .i_periph(i_periph), .i_pc_pin(pc_pin[5:0]),
    .o_pc_out(pc_out), .o_pc_oe(pc_oe), .i_pd_pin(pd_pin), .o_pd_out(pd_out), .o_pd_oe(pd_oe),
    .i_pe_pin(pe_pin), .o_pe_out(pe_out), .o_pe_oe(pe_oe), .o_pe_pin_sync(pe_sync));
  gpc_pin_model i_pc (.i_out({2'h0, pc_out}), .i_oe({2'h0, pc_oe}), .i_ext(ext_c), .o_pin(pc_pin));
  gpc_pin_model i_pd (.i_out(pd_out), .i_oe(pd_oe), .i_ext(ext_d), .o_pin(pd_pin));
  gpc_pin_model i_pe (.i_out(pe_out), .i_oe(pe_oe), .i_ext(ext_e), .o_pin(pe_pin));
  // ----------------------------------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t value mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // Read data are taken in the single cycle after the strobe
  task automatic rdr(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic settle();
    repeat (6) @(posedge i_clk);
    #1;
  endtask
  task automatic do_reset();
    @(posedge i_clk);
    i_reset <= 1'b1;
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdr(GPC_OFS_PORT_C_DIR, rd); check(rd, 8'h00);
    rdr(GPC_OFS_PORT_D_DIR, rd); check(rd, 8'h00);
    rdr(GPC_OFS_PORT_E_DIR, rd); check(rd, 8'h00);
    check({2'h0, pc_oe}, 8'h00);
    check(pd_oe | pe_oe, 8'h00);
    rdr(4'h0, rd); check(rd, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_port_c();
    ext_c <= 8'h2A;
    wr(GPC_OFS_PORT_C_LATCH, 8'h15);
    wr(GPC_OFS_PORT_C_DIR, 8'h0F);
    settle();
    check({2'h0, pc_oe}, 8'h0F);
    check({2'h0, pc_out & 6'h0F}, 8'h05);
    rdr(GPC_OFS_PORT_C_LATCH, rd); check(rd, 8'h25);
    wr(GPC_OFS_PORT_C_LATCH, 8'h3F);
    rdr(GPC_OFS_PORT_C_LATCH, rd); check(rd, 8'h2F);
    $display("test port c done");
  endtask
  task automatic t_clk_out();
    wr(GPC_OFS_PORT_C_DIR, 8'h80);
    @(posedge i_clk); #1;
    check({7'h0, pc_oe[2]}, 8'h01);
    check({7'h0, pc_out[2]}, 8'h01);
    @(negedge i_clk); #1;
    check({7'h0, pc_out[2]}, 8'h00);
    rdr(GPC_OFS_PORT_C_DIR, rd); check(rd, 8'h80);
    $display("test clock out done");
  endtask
  task automatic t_port_d();
    ext_d <= 8'h3D;
    wr(GPC_OFS_PORT_D_LATCH, 8'hA5);
    wr(GPC_OFS_PORT_D_DIR, 8'hF0);
    settle();
    check(pd_oe, 8'hF0);
    check(pd_out & pd_oe, 8'hA0);
    rdr(GPC_OFS_PORT_D_LATCH, rd); check(rd, 8'hAD);
    @(posedge i_clk);
    i_ctrl.conv_sel <= GPC_CONV_D_FIRST;
    i_ctrl.ta_prescale <= GPC_PS_EXT_CLK;
    i_ctrl.tb_prescale <= GPC_PS_EXT_CLK;
    rdr(GPC_OFS_PORT_D_LATCH, rd); check(rd, 8'hAC);
    check(pd_oe, 8'hA0);
    check(pd_out & pd_oe, 8'hA0);
    $display("test port d done");
  endtask
  task automatic t_port_e();
    ext_e <= 8'hC3;
    wr(GPC_OFS_PORT_E_LATCH, 8'h5A);
    wr(GPC_OFS_PORT_E_DIR, 8'h12);
    settle();
    check(pe_oe, 8'h12);
    rdr(GPC_OFS_PORT_E_LATCH, rd); check(rd, 8'hD3);
    check(pe_sync, 8'hD3);
    @(posedge i_clk);
    i_ctrl.spi_en <= 1'b1;
    i_ctrl.sci_en <= 1'b1;
    i_ctrl.ta_ch0_els <= 2'h1;
    i_periph <= '{spi_clk_out: 1'b1, spi_mosi_out: 1'b0, spi_miso_out: 1'b1, ta_ch_out: 2'h1,
                  ta_ch_oe: 2'h1, sci_txd: 1'b1};
    @(posedge i_clk); #1;
    check(pe_oe, 8'h25);
    check(pe_out & pe_oe, 8'h25);
    @(posedge i_clk);
    i_ctrl.spi_master <= 1'b1;
    @(posedge i_clk); #1;
    check(pe_oe, 8'hD5);
    check(pe_out & pe_oe, 8'h95);
    rdr(GPC_OFS_PORT_E_LATCH, rd); check(rd[4], 1'b1);
    @(posedge i_clk);
    i_ctrl.mode_fault_en <= 1'b1;
    @(posedge i_clk); #1;
    check(pe_oe, 8'hC5);
    $display("test port e done");
  endtask
  task automatic t_latch_keep();
    do_reset();
    check({2'h0, pc_oe}, 8'h00);
    wr(GPC_OFS_PORT_C_DIR, 8'h3F);
    rdr(GPC_OFS_PORT_C_LATCH, rd); check(rd, 8'h3F);
    $display("test latch keep done");
  endtask
  // ----------------------------------------------------------------
  // Verdict and main sequence
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    t_reset();
    t_port_c();
    t_clk_out();
    t_port_d();
    t_port_e();
    t_latch_keep();
    print_verdict();
  end
endmodule
